//--- design/rpsms_pkg.sv
package rpsms_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned RPSMS_DRIVE_CYCLES  = 34;
   localparam int unsigned RPSMS_SAMPLE_CYCLES = 38;
   localparam int unsigned RPSMS_DBG_BIT_TICKS = 16;
   localparam int unsigned RPSMS_CNT_W         = 6;

   // ----------------------------------------
   // Reset cause register layout
   // ----------------------------------------
   localparam int unsigned RPSMS_CAUSE_W   = 4;
   localparam int unsigned RPSMS_CAUSE_POR = 0;
   localparam int unsigned RPSMS_CAUSE_LVD = 1;
   localparam int unsigned RPSMS_CAUSE_WDG = 2;
   localparam int unsigned RPSMS_CAUSE_PIN = 3;
   localparam logic [3:0]  RPSMS_CAUSE_RST = 4'h1;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      RPSMS_SRC_NONE,
      RPSMS_SRC_LVD,
      RPSMS_SRC_WDG
   } rpsms_src_t;

   typedef enum {
      RPSMS_ST_IDLE,
      RPSMS_ST_DRIVE,
      RPSMS_ST_WAIT,
      RPSMS_ST_RUN
   } rpsms_state_t;

   typedef struct packed {
      logic clk_internal;
      logic port_outputs_off;
      logic port_pullups_off;
   } rpsms_defaults_t;

endpackage : rpsms_pkg

//--- design/rpsms_sequencer.sv
`timescale 1ns/1ps

// Operation
// - On any reset the block drives the reset pin low for 34 bus cycles.
// - After those cycles the block releases the reset pin to its pull-up.
// - 38 cycles after release the block samples the reset pin once.
// - A high sample attributes the reset to the pending internal source.
// - A low sample classifies the reset as external regardless of internal requests.
// - The decoded cause sets the matching bit of the reset cause register.
// - During reset the debug pin is used only as a mode-select input.
// - A high mode-select level at reset release selects normal run mode.
// - A low mode-select level held across reset release selects background mode.
// - Right after reset the shared pin is handed to the serial debug controller.
// - Each debug bit lasts 16 debug clock ticks.
// - The releasing party drives the debug pin high briefly as a speed-up pulse.
// - After reset the internal clock generator clock is selected.
// - After reset all port pins are high-impedance inputs with pull-ups off.
module rpsms_sequencer
   import rpsms_pkg::*;
#(
   parameter int unsigned DRIVE_CYCLES  = RPSMS_DRIVE_CYCLES,
   parameter int unsigned SAMPLE_CYCLES = RPSMS_SAMPLE_CYCLES
) (
   input  wire logic                     clock_in,
   input  wire logic                     rst_in,
   input  wire logic                     por_in,
   input  wire logic                     lvd_req_in,
   input  wire logic                     wdg_req_in,
   input  wire logic                     reset_pin_in,
   input  wire logic                     mode_pin_in,
   input  wire logic                     debug_drive_in,
   input  wire logic                     debug_level_in,
   output logic                          reset_pin_out,
   output logic                          reset_pin_oe_out,
   output logic                          internal_reset_out,
   output logic [RPSMS_CAUSE_W-1:0]      reset_cause_register_out,
   output logic                          background_mode_out,
   output logic                          debug_pin_owned_out,
   output logic                          debug_mode_select_pin_out,
   output logic                          debug_mode_select_pin_oe_out,
   output rpsms_defaults_t               defaults_out
);

   // ----------------------------------------
   // State and counters
   // ----------------------------------------
   rpsms_state_t            state;
   rpsms_state_t            next_state;
   logic [RPSMS_CNT_W-1:0]  count;
   logic [RPSMS_CNT_W-1:0]  next_count;
   rpsms_src_t              src;
   logic                    pin_fell_q;

   localparam logic [RPSMS_CNT_W-1:0] DRIVE_LAST  = RPSMS_CNT_W'(DRIVE_CYCLES - 1);
   localparam logic [RPSMS_CNT_W-1:0] SAMPLE_LAST = RPSMS_CNT_W'(SAMPLE_CYCLES - 1);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire internal_req = lvd_req_in | wdg_req_in;
   // External reset seen only while we are not driving the pin ourselves
   wire pin_req      = (state == RPSMS_ST_RUN) & ~reset_pin_in & ~pin_fell_q;
   wire any_req      = internal_req | pin_req;
   wire drive_done   = (state == RPSMS_ST_DRIVE) & (count == DRIVE_LAST);
   wire sample_now   = (state == RPSMS_ST_WAIT) & (count == SAMPLE_LAST);
   wire pin_high     = reset_pin_in;

   always_comb begin
      next_state = state;
      next_count = count + RPSMS_CNT_W'(1);
      unique case (state)
         RPSMS_ST_IDLE: begin
            next_state = RPSMS_ST_DRIVE;
            next_count = '0;
         end
         RPSMS_ST_DRIVE: begin
            if (drive_done) begin
               next_state = RPSMS_ST_WAIT;
               next_count = '0;
            end
         end
         RPSMS_ST_WAIT: begin
            if (sample_now) begin
               next_state = RPSMS_ST_RUN;
               next_count = '0;
            end
         end
         RPSMS_ST_RUN: begin
            next_count = '0;
            if (any_req) begin
               next_state = RPSMS_ST_DRIVE;
            end
         end
      endcase
   end

   // ----------------------------------------
   // Sequencer registers
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state <= RPSMS_ST_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Internal source latched; watchdog wins when both request at once
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         src <= RPSMS_SRC_NONE;
      end else if (state == RPSMS_ST_RUN && any_req) begin
         src <= wdg_req_in ? RPSMS_SRC_WDG : (lvd_req_in ? RPSMS_SRC_LVD : RPSMS_SRC_NONE);
      end else if (state == RPSMS_ST_IDLE) begin
         src <= RPSMS_SRC_NONE;
      end
   end

   // Hold off pin detection until the pin has risen after release
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pin_fell_q <= 1'b0;
      end else if (state == RPSMS_ST_RUN && reset_pin_in) begin
         pin_fell_q <= 1'b0;
      end else if (pin_req) begin
         pin_fell_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Reset pin drive and cause
   // ----------------------------------------
   wire next_drive = (next_state == RPSMS_ST_DRIVE);
   wire por_cycle  = (state == RPSMS_ST_IDLE);

   // Power-on cause is a plain input sampled at the first clocked cycle
   logic por_seen;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         por_seen <= 1'b1;
      end else if (state == RPSMS_ST_RUN && any_req) begin
         por_seen <= 1'b0;
      end else if (por_cycle) begin
         por_seen <= por_in;
      end
   end

   logic [RPSMS_CAUSE_W-1:0] next_cause;
   always_comb begin
      next_cause = '0;
      if (!pin_high) begin
         next_cause[RPSMS_CAUSE_PIN] = 1'b1;
      end else if (src == RPSMS_SRC_WDG) begin
         next_cause[RPSMS_CAUSE_WDG] = 1'b1;
      end else if (src == RPSMS_SRC_LVD) begin
         next_cause[RPSMS_CAUSE_LVD] = 1'b1;
      end else begin
         next_cause[RPSMS_CAUSE_POR] = por_seen;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         reset_pin_out            <= 1'b0;
         reset_pin_oe_out         <= 1'b1;
         internal_reset_out       <= 1'b1;
         reset_cause_register_out <= RPSMS_CAUSE_RST;
      end else begin
         reset_pin_out      <= 1'b0;
         reset_pin_oe_out   <= next_drive;
         internal_reset_out <= (next_state != RPSMS_ST_RUN);
         if (sample_now) begin
            reset_cause_register_out <= next_cause;
         end
      end
   end

   // ----------------------------------------
   // Mode select and debug pin handover
   // ----------------------------------------
   // Pin is input only during reset; ignored afterwards until next reset
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         background_mode_out <= 1'b0;
         debug_pin_owned_out <= 1'b0;
      end else if (sample_now) begin
         background_mode_out <= ~mode_pin_in;
         debug_pin_owned_out <= 1'b1;
      end else if (next_state != RPSMS_ST_RUN) begin
         debug_pin_owned_out <= 1'b0;
      end
   end

   // Debug controller drives bit timing and speed-up pulses itself
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         debug_mode_select_pin_out    <= 1'b0;
         debug_mode_select_pin_oe_out <= 1'b0;
      end else begin
         debug_mode_select_pin_out    <= debug_level_in;
         debug_mode_select_pin_oe_out <= debug_drive_in & debug_pin_owned_out
                                         & (next_state == RPSMS_ST_RUN);
      end
   end

   // ----------------------------------------
   // Post-reset defaults
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         defaults_out <= '{clk_internal: 1'b1, port_outputs_off: 1'b1, port_pullups_off: 1'b1};
      end else if (next_state != RPSMS_ST_RUN) begin
         defaults_out <= '{clk_internal: 1'b1, port_outputs_off: 1'b1,
                           port_pullups_off: 1'b1};
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_drive_len;
      @(posedge clock_in) disable iff (rst_in)
      $rose(reset_pin_oe_out) |-> reset_pin_oe_out [*8] ##0 (state == RPSMS_ST_DRIVE);
   endproperty
   a_drive_len: assert property (p_drive_len) else $error("reset pin drive too short");

   property p_release;
      @(posedge clock_in) disable iff (rst_in)
      drive_done |=> !reset_pin_oe_out;
   endproperty
   a_release: assert property (p_release) else $error("reset pin not released");

   property p_sample_point;
      @(posedge clock_in) disable iff (rst_in)
      $fell(reset_pin_oe_out) |-> ##37 sample_now;
   endproperty
   a_sample_point: assert property (p_sample_point) else $error("sample point wrong");

   property p_external;
      @(posedge clock_in) disable iff (rst_in)
      (sample_now && !reset_pin_in) |=> reset_cause_register_out[RPSMS_CAUSE_PIN];
   endproperty
   a_external: assert property (p_external) else $error("low sample not external");

   property p_internal;
      @(posedge clock_in) disable iff (rst_in)
      (sample_now && reset_pin_in && src == RPSMS_SRC_WDG)
         |=> reset_cause_register_out[RPSMS_CAUSE_WDG];
   endproperty
   a_internal: assert property (p_internal) else $error("watchdog cause lost");

   property p_onehot;
      @(posedge clock_in) disable iff (rst_in)
      $onehot0(reset_cause_register_out);
   endproperty
   a_onehot: assert property (p_onehot) else $error("cause not one-hot");

   property p_mode;
      @(posedge clock_in) disable iff (rst_in)
      sample_now |=> (background_mode_out == !$past(mode_pin_in));
   endproperty
   a_mode: assert property (p_mode) else $error("mode capture wrong");

   property p_hold_mode;
      @(posedge clock_in) disable iff (rst_in)
      (state == RPSMS_ST_RUN && $past(state) == RPSMS_ST_RUN) |-> $stable(background_mode_out);
   endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("mode changed in run");

   property p_no_drive_in_reset;
      @(posedge clock_in) disable iff (rst_in)
      internal_reset_out |-> !debug_mode_select_pin_oe_out;
   endproperty
   a_no_drive_in_reset: assert property (p_no_drive_in_reset)
      else $error("debug pin driven in reset");

   property p_defaults;
      @(posedge clock_in) disable iff (rst_in)
      internal_reset_out |=> defaults_out.clk_internal && defaults_out.port_pullups_off;
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults wrong");

   c_external: cover property (@(posedge clock_in) disable iff (rst_in)
      sample_now && !reset_pin_in);
   c_watchdog: cover property (@(posedge clock_in) disable iff (rst_in)
      sample_now && reset_pin_in && src == RPSMS_SRC_WDG);
   c_background: cover property (@(posedge clock_in) disable iff (rst_in)
      sample_now && !mode_pin_in);

endmodule : rpsms_sequencer

//--- verification/rpsms_far_side_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Reset switch and debug pod on the far side
// ----------------------------------------
module rpsms_far_side_model (
   input  wire logic hold_reset_low_in,
   input  wire logic mode_low_in,
   input  wire logic rst_drv_out_in,
   input  wire logic rst_drv_oe_in,
   input  wire logic dbg_drv_out_in,
   input  wire logic dbg_drv_oe_in,
   output logic      reset_level_out,
   output logic      mode_level_out
);
   // Light load: pin is back at pull-up level on release
   wire   rst_pulled_low = rst_drv_oe_in & ~rst_drv_out_in;
   assign reset_level_out = (rst_pulled_low | hold_reset_low_in) ? 1'b0 : 1'b1;
   // Pod holds the pin low across reset release to ask for background mode
   assign mode_level_out = dbg_drv_oe_in ? dbg_drv_out_in :
                           (mode_low_in ? 1'b0 : 1'b1);
endmodule : rpsms_far_side_model

//--- verification/testbench.sv
`timescale 1ns/1ps

module testbench;
   import rpsms_pkg::*;

   logic clock_in = 0, rst_in = 1, por_in = 1, lvd = 0, wdg = 0;
   logic hold_low = 0, mode_low = 1, dbg_drive = 0, dbg_level = 0;
   logic rp_in, mp_in, rp_out, rp_oe, int_rst, bg, owned, dm_out, dm_oe;
   logic [RPSMS_CAUSE_W-1:0] cause;
   rpsms_defaults_t          dflt;
   int n_errors = 0, checks = 0, seed = 51269;

   rpsms_sequencer dut (.clock_in(clock_in), .rst_in(rst_in), .por_in(por_in),
      .lvd_req_in(lvd), .wdg_req_in(wdg), .reset_pin_in(rp_in), .mode_pin_in(mp_in),
      .debug_drive_in(dbg_drive), .debug_level_in(dbg_level), .reset_pin_out(rp_out),
      .reset_pin_oe_out(rp_oe), .internal_reset_out(int_rst),
      .reset_cause_register_out(cause), .background_mode_out(bg),
      .debug_pin_owned_out(owned), .debug_mode_select_pin_out(dm_out),
      .debug_mode_select_pin_oe_out(dm_oe), .defaults_out(dflt));

   rpsms_far_side_model far (.hold_reset_low_in(hold_low), .mode_low_in(mode_low),
      .rst_drv_out_in(rp_out), .rst_drv_oe_in(rp_oe), .dbg_drv_out_in(dm_out),
      .dbg_drv_oe_in(dm_oe), .reset_level_out(rp_in), .mode_level_out(mp_in));

   initial begin
      forever #10 clock_in = ~clock_in;
   end

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic logic [3:0] exp_cause(input bit pin_low, input bit l, input bit w);
      logic [3:0] c;
      c = 4'h0;
      if (pin_low) c[RPSMS_CAUSE_PIN] = 1'b1;
      else if (w) c[RPSMS_CAUSE_WDG] = 1'b1;
      else if (l) c[RPSMS_CAUSE_LVD] = 1'b1;
      else c[RPSMS_CAUSE_POR] = 1'b1;
      return c;
   endfunction : exp_cause

   task automatic give_verdict();
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   // ----------------------------------------
   // One reset sequence, measured at the pins
   // ----------------------------------------
   task automatic measure(input logic [3:0] ecause, input bit ebg);
      int n;
      n = 0;
      while (rp_oe !== 1'b1 && n < 8) begin
         @(negedge clock_in);
         n++;
      end
      @(posedge clock_in);
      lvd <= 1'b0;
      wdg <= 1'b0;
      @(negedge clock_in);
      n = 1;
      check("owned_in_reset", 32'h0, owned);
      while (rp_oe === 1'b1 && n < 200) begin
         check("dbg_oe_in_reset", 32'h0, dm_oe);
         check("reset_pin_level", 32'h0, rp_in);
         @(negedge clock_in);
         n++;
      end
      check("drive_cycles", RPSMS_DRIVE_CYCLES, n);
      n = 0;
      while (int_rst === 1'b1 && n < 200) begin
         check("released", 32'h0, rp_oe);
         @(negedge clock_in);
         n++;
      end
      check("sample_cycles", RPSMS_SAMPLE_CYCLES, n);
      check("cause", ecause, cause);
      check("background", ebg, bg);
      check("owned", 32'h1, owned);
      check("defaults", 32'h7, dflt);
      @(posedge clock_in);
      hold_low <= 1'b0;
      mode_low <= 1'b0;
      repeat (3) @(posedge clock_in);
      mode_low <= ~ebg;
      @(negedge clock_in);
      check("mode_held", ebg, bg);
   endtask : measure

   // Trigger: 0 pin, 1 lvd, 2 wdg, 3 both; hold keeps the pin low past the sample
   task automatic run_seq(input int trig, input bit mlow, input bit hold);
      bit pin;
      pin = hold || trig == 0;
      @(posedge clock_in);
      mode_low <= mlow;
      lvd <= (trig == 1 || trig == 3);
      wdg <= (trig == 2 || trig == 3);
      hold_low <= pin;
      measure(exp_cause(pin, trig == 1 || trig == 3, trig >= 2), mlow);
   endtask : run_seq

   // Debug controller drives one whole bit time through the owned pin, one cycle later
   task automatic dbg_pass(input logic lvl);
      @(posedge clock_in);
      dbg_drive <= 1'b1;
      dbg_level <= lvl;
      repeat (RPSMS_DBG_BIT_TICKS - 1) begin
         @(posedge clock_in);
         @(negedge clock_in);
         check("dbg_oe_bit", 32'h1, dm_oe);
      end
      @(posedge clock_in);
      dbg_drive <= 1'b0;
      @(negedge clock_in);
      check("dbg_oe", 32'h1, dm_oe);
      check("dbg_out", lvl, dm_out);
      @(negedge clock_in);
      check("dbg_oe_off", 32'h0, dm_oe);
   endtask : dbg_pass

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int trig;
      bit mlow;
      bit hold;
      repeat (10) @(posedge clock_in);
      rst_in <= 1'b0;
      // First clocked cycle after release stands in for the request edge
      @(posedge clock_in);
      measure(4'h1, 1'b1);
      por_in <= 1'b0;
      dbg_pass(1'b1);
      run_seq(2, 1'b0, 1'b0);
      run_seq(3, 1'b1, 1'b0);
      run_seq(1, 1'b0, 1'b1);
      run_seq(0, 1'b1, 1'b0);
      repeat (12) begin
         trig = $unsigned($random(seed)) % 4;
         mlow = $random(seed);
         hold = $random(seed);
         run_seq(trig, mlow, hold);
         dbg_pass($random(seed));
      end
      give_verdict();
   end

   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end
endmodule : testbench
